// ==== verilog/egress_regs_defs.svh ====
// offsets, field positions, reset values and timing counts for the egress/vlan register slice
// assumes inclusion by bare name from the package and the modules
`ifndef EGRESS_REGS_DEFS_SVH
`define EGRESS_REGS_DEFS_SVH

`define ADDR_W               16
`define OFS_P2_Q01_RATE      16'h1C11
`define OFS_P2_Q23_RATE      16'h1C12
`define OFS_HOST_TAG         16'h1C13
`define OFS_P1_TAG           16'h1C14
`define OFS_P2_TAG           16'h1C15
`define OFS_HOST_DROP_CNT    16'h1C16
`define OFS_IRQ_STATUS       16'h1C30
`define OFS_IRQ_MASK         16'h1C31

`define RATE_W               13
`define RATE_LO_LSB          0
`define RATE_HI_LSB          13
`define VID_W                12
`define VID_LSB              0
`define PRIO_W               3
`define PRIO_LSB             12
`define RATE_RST             13'h0000
`define TAG_RST              15'h0000
`define CNT_RST              32'h00000000
`define CNT_MAX              32'hFFFFFFFF
`define IRQ_W                2
`define IRQ_DROP_BIT         0
`define IRQ_SAT_BIT          1
`define IRQ_MASK_RST         2'h3

`define BYTE_TIME_NS         20
`define CLK_PERIOD_NS        4
`define BYTE_TIME_CYC        ((`BYTE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== verilog/egress_regs_pkg.sv ====
// types shared by the egress rate / default tag register slice
// assumes egress_regs_defs.svh is on the include path
package egress_regs_pkg;
  `include "egress_regs_defs.svh"
  typedef enum logic [1:0] {
    PACE_IDLE = 2'b00,
    PACE_WAIT = 2'b01
  } pace_state_t;
endpackage

// ==== verilog/byte_pacer.sv ====
// per-queue egress pacer: spends (rate+1) x byte time for every byte sent
// assumes byte_req_i is held until byte_go_o answers
`timescale 1ns/1ps
`include "egress_regs_defs.svh"
module byte_pacer
  import egress_regs_pkg::*;
#(
  parameter int RATE_W   = `RATE_W,
  parameter int UNIT_CYC = `BYTE_TIME_CYC
) (
  input  wire logic              clk_i,
  input  wire logic              srst_i,
  input  wire logic              ce_i,
  input  wire logic [RATE_W-1:0] rate_i,
  input  wire logic              byte_req_i,
  output logic                   byte_go_o
);
  localparam int UW = $clog2(UNIT_CYC + 1);
  pace_state_t       state_ff;
  logic [RATE_W-1:0] units_ff;
  logic [UW-1:0]     sub_ff;
  logic              slot_end;

  // last cycle of a slot; a waiting byte goes here so a busy queue spends
  // exactly (rate+1) units per byte, with no extra idle cycle in between
  assign slot_end  = (state_ff == PACE_WAIT) & (sub_ff == '0) & (units_ff == '0);
  assign byte_go_o = ((state_ff == PACE_IDLE) | slot_end) & byte_req_i & ce_i;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_ff <= PACE_IDLE;
      units_ff <= '0;
      sub_ff   <= '0;
    end else if (ce_i) begin
      case (state_ff)
        PACE_IDLE: begin
          if (byte_req_i) begin
            state_ff <= PACE_WAIT;
            units_ff <= rate_i;
            sub_ff   <= UW'(UNIT_CYC - 1);
          end
        end
        PACE_WAIT: begin
          // total (rate+1) units of UNIT_CYC cycles
          if (sub_ff != '0) begin
            sub_ff <= sub_ff - 1'b1;
          end else if (units_ff != '0) begin
            units_ff <= units_ff - 1'b1;
            sub_ff   <= UW'(UNIT_CYC - 1);
          end else if (byte_req_i) begin
            // back-to-back byte: start the next slot at once
            units_ff <= rate_i;
            sub_ff   <= UW'(UNIT_CYC - 1);
          end else begin
            state_ff <= PACE_IDLE;
          end
        end
        default: state_ff <= PACE_IDLE;
      endcase
    end
  end
endmodule

// ==== verilog/egress_rate_vlan_regs.sv ====
// egress rate, default tag and host drop counter registers with queue pacers
// assumes a single-cycle strobe master; drop events are one-cycle pulses
// Functional notes
// - Port 2 queue 0 rate sits in bits 12:0 and queue 1 rate in bits 25:13 of one register.
// - Port 2 queue 2 rate sits in bits 12:0 and queue 3 rate in bits 25:13 of a second register.
// - Each queue spends (field value plus one) times 20 ns per transmitted byte.
// - A 3-bit default priority per port goes into the tag priority when a tag is inserted or changed.
// - A 12-bit default VLAN id per port is used when a tag is inserted or changed.
// - Host, port 1 and port 2 each have their own default tag register applied only to that port.
// - A 32-bit counter counts host-port packets dropped by ingress rate limiting, red or yellow.
// - Reading the drop counter returns it and clears it; it is zero after reset.
// - The drop counter saturates at all ones and holds until read.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`include "egress_regs_defs.svh"
module egress_rate_vlan_regs
  import egress_regs_pkg::*;
#(
  parameter int NQ       = 4,
  parameter int NPORT    = 3,
  parameter int UNIT_CYC = `BYTE_TIME_CYC
) (
  input  wire logic               clk_i,
  input  wire logic               srst_i,
  input  wire logic               ce_i,
  input  wire logic [`ADDR_W-1:0] addr_i,
  input  wire logic [31:0]        wdata_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  output logic      [31:0]        rdata_o,
  output logic                    irq_o,
  input  wire logic [NQ-1:0]      p2_byte_req_i,
  output logic      [NQ-1:0]      p2_byte_go_o,
  input  wire logic [NPORT-1:0]   tag_edit_i,
  input  wire logic [NPORT*16-1:0] tag_tci_i,
  output logic      [NPORT*16-1:0] tag_tci_o,
  input  wire logic               host_red_drop_i,
  input  wire logic               host_yellow_drop_i
);
  logic [`RATE_W-1:0] rate_ff [NQ];
  logic [14:0]        tag_ff  [NPORT];
  logic [31:0]        drop_cnt_ff;
  logic [`IRQ_W-1:0]  irq_stat_ff;
  logic [`IRQ_W-1:0]  irq_mask_ff;
  logic [31:0]        rdata_ff;
  logic [31:0]        nxt_rdata;
  logic               drop_evt;
  logic               rd_cnt;
  logic               rd_stat;
  logic               cnt_sat;

  assign drop_evt = host_red_drop_i | host_yellow_drop_i;
  assign rd_cnt   = rd_i & (addr_i == `OFS_HOST_DROP_CNT);
  assign rd_stat  = rd_i & (addr_i == `OFS_IRQ_STATUS);
  assign cnt_sat  = (drop_cnt_ff == `CNT_MAX);

  // rate fields: two queues per word
  genvar q;
  generate
    for (q = 0; q < NQ; q++) begin : g_rate
      localparam logic [`ADDR_W-1:0] OFS = (q < 2) ? `OFS_P2_Q01_RATE : `OFS_P2_Q23_RATE;
      localparam int LSB = (q % 2 == 0) ? `RATE_LO_LSB : `RATE_HI_LSB;
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          rate_ff[q] <= `RATE_RST;
        end else if (ce_i && wr_i && addr_i == OFS) begin
          rate_ff[q] <= wdata_i[LSB +: `RATE_W];
        end
      end
      byte_pacer #(
        .RATE_W   (`RATE_W),
        .UNIT_CYC (UNIT_CYC)
      ) u_pacer (
        .clk_i      (clk_i),
        .srst_i     (srst_i),
        .ce_i       (ce_i),
        .rate_i     (rate_ff[q]),
        .byte_req_i (p2_byte_req_i[q]),
        .byte_go_o  (p2_byte_go_o[q])
      );
    end
  endgenerate

  // default tag per port; only that port's tci is rewritten
  genvar p;
  generate
    for (p = 0; p < NPORT; p++) begin : g_tag
      localparam logic [`ADDR_W-1:0] OFS = (p == 0) ? `OFS_HOST_TAG :
                                           (p == 1) ? `OFS_P1_TAG : `OFS_P2_TAG;
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          tag_ff[p] <= `TAG_RST;
        end else if (ce_i && wr_i && addr_i == OFS) begin
          tag_ff[p] <= wdata_i[14:0];
        end
      end
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          tag_tci_o[p*16 +: 16] <= 16'h0000;
        end else if (ce_i) begin
          if (tag_edit_i[p]) begin
            // cfi bit passes through from the frame
            tag_tci_o[p*16 +: 16] <= {tag_ff[p][`PRIO_LSB +: `PRIO_W],
                                      tag_tci_i[p*16 + 12],
                                      tag_ff[p][`VID_LSB +: `VID_W]};
          end else begin
            tag_tci_o[p*16 +: 16] <= tag_tci_i[p*16 +: 16];
          end
        end
      end
    end
  endgenerate

  // host drop counter: a drop landing in the read cycle counts as 1 after clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      drop_cnt_ff <= `CNT_RST;
    end else if (ce_i) begin
      if (rd_cnt) begin
        drop_cnt_ff <= drop_evt ? 32'h00000001 : `CNT_RST;
      end else if (drop_evt && !cnt_sat) begin
        drop_cnt_ff <= drop_cnt_ff + 32'h00000001;
      end
    end
  end

  // sticky status: set wins over the read clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_stat_ff <= '0;
    end else if (ce_i) begin
      irq_stat_ff <= (rd_stat ? '0 : irq_stat_ff)
                   | {(drop_evt & (drop_cnt_ff == (`CNT_MAX - 32'h00000001)) & !rd_cnt),
                      drop_evt};
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_mask_ff <= `IRQ_MASK_RST;
    end else if (ce_i && wr_i && addr_i == `OFS_IRQ_MASK) begin
      irq_mask_ff <= wdata_i[`IRQ_W-1:0];
    end
  end

  assign irq_o = |(irq_stat_ff & ~irq_mask_ff);

  always_comb begin
    nxt_rdata = 32'h00000000;
    case (addr_i)
      `OFS_P2_Q01_RATE:   nxt_rdata = {6'h00, rate_ff[1], rate_ff[0]};
      `OFS_P2_Q23_RATE:   nxt_rdata = {6'h00, rate_ff[3], rate_ff[2]};
      `OFS_HOST_TAG:      nxt_rdata = {17'h00000, tag_ff[0]};
      `OFS_P1_TAG:        nxt_rdata = {17'h00000, tag_ff[1]};
      `OFS_P2_TAG:        nxt_rdata = {17'h00000, tag_ff[2]};
      `OFS_HOST_DROP_CNT: nxt_rdata = drop_cnt_ff;
      `OFS_IRQ_STATUS:    nxt_rdata = {30'h00000000, irq_stat_ff};
      `OFS_IRQ_MASK:      nxt_rdata = {30'h00000000, irq_mask_ff};
      default:            nxt_rdata = 32'h00000000;
    endcase
  end

  // read data only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_ff <= 32'h00000000;
    end else if (ce_i) begin
      rdata_ff <= rd_i ? nxt_rdata : 32'h00000000;
    end
  end

  assign rdata_o = rdata_ff;
endmodule

// ==== verification/egress_regs_props.sv ====
// checker for the egress rate / default tag register slice
// assumes only the top module ports are visible; one clock domain
`timescale 1ns/1ps
module egress_regs_chk
  import egress_regs_pkg::*;
#(parameter int NQ = 4, parameter int NPORT = 3, parameter int UNIT_CYC = 5) (
  input wire logic               clk_i, srst_i, ce_i, wr_i, rd_i, irq_o,
  input wire logic               host_red_drop_i, host_yellow_drop_i,
  input wire logic [15:0]        addr_i,
  input wire logic [31:0]        wdata_i, rdata_o,
  input wire logic [NQ-1:0]      p2_byte_req_i, p2_byte_go_o,
  input wire logic [NPORT-1:0]   tag_edit_i,
  input wire logic [NPORT*16-1:0] tag_tci_i, tag_tci_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  wire drp    = host_red_drop_i | host_yellow_drop_i;
  wire cnt_rd = rd_i && ce_i && addr_i == 16'h1C16 && !drp;
  property p_rd_idle; !rd_i |=> rdata_o == 32'h0; endproperty
  property p_rate_rsv; rd_i && ce_i && addr_i inside {16'h1C11, 16'h1C12}
    |=> rdata_o[31:26] == 6'h0; endproperty
  property p_tag_rsv; rd_i && ce_i && addr_i inside {[16'h1C13:16'h1C15]}
    |=> rdata_o[31:15] == 17'h0; endproperty
  property p_cnt_clr; cnt_rd ##1 !drp ##1 cnt_rd |=> rdata_o == 32'h0; endproperty
  // a one-cycle unit lets a rate-0 queue release a byte every cycle
  property p_go_gap; |p2_byte_go_o
    |=> UNIT_CYC < 2 || (p2_byte_go_o & $past(p2_byte_go_o)) == '0; endproperty
  property p_go_ce; !ce_i |-> p2_byte_go_o == '0; endproperty
  property p_tag_pass; ce_i && !tag_edit_i[1]
    |=> tag_tci_o[31:16] == $past(tag_tci_i[31:16]); endproperty
  property p_tag_cfi; ce_i && tag_edit_i[0] |=> tag_tci_o[12] == $past(tag_tci_i[12]); endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
  a_rate_rsv: assert property (p_rate_rsv) else $error("rate reserved bits");
  a_tag_rsv: assert property (p_tag_rsv) else $error("tag reserved bits");
  a_cnt_clr: assert property (p_cnt_clr) else $error("count not cleared");
  a_go_gap: assert property (p_go_gap) else $error("go twice in a row");
  a_go_ce: assert property (p_go_ce) else $error("go while frozen");
  a_tag_pass: assert property (p_tag_pass) else $error("port 1 tci altered");
  a_tag_cfi: assert property (p_tag_cfi) else $error("host cfi altered");
  c_go: cover property (|p2_byte_go_o);
  c_cnt: cover property (cnt_rd ##1 rdata_o != 32'h0);
  c_irq: cover property (irq_o);
endmodule
bind egress_rate_vlan_regs egress_regs_chk #(.NQ(NQ), .NPORT(NPORT), .UNIT_CYC(UNIT_CYC))
  i_chk (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .wr_i(wr_i), .rd_i(rd_i), .irq_o(irq_o),
  .host_red_drop_i(host_red_drop_i), .host_yellow_drop_i(host_yellow_drop_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .rdata_o(rdata_o), .p2_byte_req_i(p2_byte_req_i),
  .p2_byte_go_o(p2_byte_go_o), .tag_edit_i(tag_edit_i), .tag_tci_i(tag_tci_i),
  .tag_tci_o(tag_tci_o));

// ==== verification/tb.sv ====
// self-checking bench for the egress rate / default tag register slice
// assumes pacer unit shortened to two cycles, so a byte takes 2*(rate+1) cycles
`timescale 1ns/1ps
module tb;
  logic        clk_i = 0, srst_i = 1, ce_i = 1, wr_i = 0, rd_i = 0, red = 0, yel = 0;
  logic [15:0] addr_i = '0;
  logic [31:0] wdata_i = '0, v;
  logic [3:0]  req = '0;
  logic [2:0]  edit = '0;
  logic [47:0] tci_in = '0;
  wire  [31:0] rdata_o;
  wire  [3:0]  go;
  wire  [47:0] tci_out;
  wire         irq;
  logic [31:0] mdl [6];
  int          error_cnt = 0, comparisons = 0, seed = 32093, n, t0;
  localparam int UNIT_CYC = 2;
  always #2 clk_i = ~clk_i;
  egress_rate_vlan_regs #(.UNIT_CYC(UNIT_CYC)) i_egress_rate_vlan_regs (.clk_i(clk_i),
    .srst_i(srst_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq), .p2_byte_req_i(req), .p2_byte_go_o(go),
    .tag_edit_i(edit), .tag_tci_i(tci_in), .tag_tci_o(tci_out), .host_red_drop_i(red),
    .host_yellow_drop_i(yel));
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(logic [15:0] a, logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk("rdata", rdata_o, e);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #80000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 6; i++) rd(16'(16'h1C11 + i), 32'h0);
    for (int i = 0; i < 6; i++) begin
      v = $random(seed);
      wr(16'(16'h1C11 + i), v);
      // reserved bits and the read-clear counter keep nothing of a write
      mdl[i] = (i < 2) ? v & 32'h03FFFFFF : (i < 5) ? v & 32'h00007FFF : 32'h0;
    end
    wr(16'h1C20, 32'hFFFFFFFF);
    for (int i = 0; i < 6; i++) rd(16'(16'h1C11 + i), mdl[i]);
    rd(16'h1C20, 32'h0);
    $display("test registers done");
    for (int p = 0; p < 3; p++) begin
      @(posedge clk_i);
      tci_in <= 48'({$random(seed), $random(seed)});
      edit <= 3'(1 << p);
      @(posedge clk_i);
      edit <= 3'h0;
      #1;
      for (int q = 0; q < 3; q++)
        chk("tci", 32'(tci_out[q*16+:16]), 32'((q == p) ? {mdl[2+q][14:12],
          tci_in[q*16+12], mdl[2+q][11:0]} : tci_in[q*16+:16]));
    end
    $display("test tags done");
    n = 3 + ($random(seed) & 7);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      red <= i[0];
      yel <= !i[0];
      @(posedge clk_i);
      red <= 1'b0;
      yel <= 1'b0;
    end
    #1 chk("irq_masked", 32'(irq), 32'h0);
    wr(16'h1C31, 32'h0);
    #1 chk("irq_set", 32'(irq), 32'h1);
    rd(16'h1C16, n);
    rd(16'h1C16, 32'h0);
    rd(16'h1C30, 32'h1);
    chk("irq_clear", 32'(irq), 32'h0);
    $display("test drops done");
    wr(16'h1C11, 32'h00004001);
    wr(16'h1C12, 32'h00008003);
    for (int q = 0; q < 4; q++) begin
      @(posedge clk_i);
      ce_i <= 1'b0;
      req[q] <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1 chk("go_frozen", 32'(go[q]), 32'h0);
      ce_i <= 1'b1;
      n = 0;
      t0 = 0;
      for (int c = 0; c < 40 && n < 2; c++) begin
        @(posedge clk_i);
        #1;
        if (go[q] === 1'b1) begin
          n++;
          if (n == 1) t0 = c;
          // queue q holds rate q+1, so (rate+1) units of UNIT_CYC cycles per byte
          else chk("go_gap", 32'(c - t0), 32'((q + 2) * UNIT_CYC));
        end
      end
      chk("go_cnt", n, 32'h2);
      req[q] <= 1'b0;
    end
    $display("test pacer done");
    give_verdict();
  end
endmodule
